// file: verilog/rmi_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RMI_DEFS_SVH
`define RMI_DEFS_SVH
`define RMI_REG_CTRL 16'h0032
`define RMI_REG_DELAY 16'h0086
`define RMI_REG_STRAP 16'h0060
`define RMI_SMI_EXTADDR 5'h0D
`define RMI_SMI_EXTDATA 5'h0E
`define RMI_OP_READ 2'b10
`define RMI_OP_WRITE 2'b01
`define RMI_CTRL_RGMII_EN 7
`define RMI_CTRL_TX_SHIFT 1
`define RMI_CTRL_RX_SHIFT 0
`define RMI_CTRL_RESET 16'h0000
`define RMI_DELAY_RESET 16'h0000
`define RMI_SKEW_STEP_PS 250
`define RMI_MCLK_KHZ 250000
`define RMI_CLK_KHZ_1000 125000
`define RMI_CLK_KHZ_100 25000
`define RMI_CLK_KHZ_10 2500
`define RMI_HALF(k) (`RMI_MCLK_KHZ / (2 * (k)) - 1)
`endif

// file: verilog/rmi_pkg.sv
// Types shared by the MAC-side interface
package rmi_pkg;
   typedef enum logic [1:0] {RMI_SPD_10, RMI_SPD_100, RMI_SPD_1000}
      rmi_speed_type;
   typedef struct packed
   {
      logic valid;
      logic error;
      logic [7:0] data;
   } rmi_beat_type;
   typedef enum logic [1:0] {SMI_IDLE, SMI_HEAD, SMI_TURN, SMI_DATA}
      rmi_smi_state_type;
endpackage

// file: verilog/rmi_mac_side_interface.sv
// PHY-side reduced gigabit MAC interface with management registers
`timescale 1ns/100ps
`include "rmi_defs.svh"
module rmi_mac_side_interface
#(
   parameter logic [4:0] PHY_ADDR = 5'h00
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Strap
   input wire logic interfaceSelectStrapPin,
   // Line side
   input wire rmi_pkg::rmi_speed_type linkSpeed,
   input wire rmi_pkg::rmi_beat_type rxBeat,
   output logic rxTake,
   output rmi_pkg::rmi_beat_type txBeat,
   output logic txStrobe,
   // MAC receive pins
   output logic rxClkPin,
   output logic [7:0] rxdPin,
   output logic rxCtlPin,
   output logic rxErPin,
   // MAC transmit pins
   input wire logic txClkPin,
   input wire logic [7:0] txdPin,
   input wire logic txCtlPin,
   input wire logic txErPin,
   // Management pins
   input wire logic mdcPin,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   // Mode and skew to the delay lines
   output logic rgmiiMode,
   output logic [3:0] txSkewSel,
   output logic [3:0] rxSkewSel
);
   import rmi_pkg::*;

   logic [10:0] txS1_r, txS2_r, txS3_r;
   logic [1:0] smiS1_r, smiS2_r, smiS3_r;
   logic strapS1_r, strapS2_r, strapDone_r, strapVal_r;
   logic [15:0] ctrl_r, delay_r, extAddr_r;
   rmi_smi_state_type smiState_r;
   logic [1:0] smiHist_r;
   logic [11:0] smiHead_r;
   logic [4:0] smiCnt_r, smiAddr_r;
   logic [15:0] smiShift_r, smiWrData_r;
   logic smiRead_r, smiMine_r, smiWr_r;
   rmi_speed_type speed_r;
   logic [7:0] halfCnt_r;
   rmi_beat_type cur_r;
   logic nibHi_r;
   logic riseCtl_r, txNib_r, txErrLow_r, txBusy_r;
   logic [3:0] riseD_r, txLow_r;

   function automatic logic [7:0] halfCount(input rmi_speed_type s);
      unique case (s)
         RMI_SPD_1000: halfCount = 8'(`RMI_HALF(`RMI_CLK_KHZ_1000));
         RMI_SPD_100: halfCount = 8'(`RMI_HALF(`RMI_CLK_KHZ_100));
         RMI_SPD_10: halfCount = 8'(`RMI_HALF(`RMI_CLK_KHZ_10));
         // The unused fourth code falls back to the slowest rate
         default: halfCount = 8'(`RMI_HALF(`RMI_CLK_KHZ_10));
      endcase
   endfunction

   function automatic logic [15:0] smiReadData(input logic [4:0] a);
      smiReadData = 16'h0000;
      if (a == `RMI_SMI_EXTADDR)
         smiReadData = extAddr_r;
      else if (a == `RMI_SMI_EXTDATA)
      begin
         if (extAddr_r == `RMI_REG_CTRL)
            smiReadData = ctrl_r;
         else if (extAddr_r == `RMI_REG_DELAY)
            smiReadData = delay_r;
         else if (extAddr_r == `RMI_REG_STRAP)
            smiReadData = {15'h0000, strapVal_r};
      end
   endfunction

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      txS1_r <= {txClkPin, txCtlPin, txErPin, txdPin};
      txS2_r <= txS1_r;
      txS3_r <= txS2_r;
      smiS1_r <= {mdcPin, mdioIn};
      smiS2_r <= smiS1_r;
      smiS3_r <= smiS2_r;
      strapS1_r <= interfaceSelectStrapPin;
      strapS2_r <= strapS1_r;
   end

   wire mdcRise = smiS2_r[1] & ~smiS3_r[1];
   wire smiBit = smiS3_r[0];
   wire [11:0] headNxt = {smiHead_r[10:0], smiBit};
   wire gmii = ~ctrl_r[`RMI_CTRL_RGMII_EN];
   wire nibbleMode = speed_r != RMI_SPD_1000;

   // ------------------------------------------------------------
   // Management frame slave
   // ------------------------------------------------------------
   // Data is taken from the stage before the edge, so it is the value
   // that was stable while the clock was still low.
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         smiState_r <= SMI_IDLE;
         smiHist_r <= 2'b00;
         smiHead_r <= 12'h000;
         smiCnt_r <= 5'h00;
         smiAddr_r <= 5'h00;
         smiShift_r <= 16'h0000;
         smiWrData_r <= 16'h0000;
         smiRead_r <= 1'b0;
         smiMine_r <= 1'b0;
         smiWr_r <= 1'b0;
         mdioOut <= 1'b0;
         mdioOe <= 1'b0;
      end
      else
      begin
         smiWr_r <= 1'b0;
         if (mdcRise)
         begin
            unique case (smiState_r)
               SMI_IDLE:
               begin
                  smiHist_r <= {smiHist_r[0], smiBit};
                  if ({smiHist_r, smiBit} == 3'b101)
                  begin
                     smiState_r <= SMI_HEAD;
                     smiCnt_r <= 5'h00;
                  end
               end
               SMI_HEAD:
               begin
                  smiHead_r <= headNxt;
                  smiCnt_r <= smiCnt_r + 5'h01;
                  if (smiCnt_r == 5'd11)
                  begin
                     smiState_r <= SMI_TURN;
                     smiCnt_r <= 5'h00;
                     smiRead_r <= headNxt[11:10] == `RMI_OP_READ;
                     smiMine_r <= headNxt[9:5] == PHY_ADDR;
                     smiAddr_r <= headNxt[4:0];
                     smiShift_r <= smiReadData(headNxt[4:0]);
                  end
               end
               SMI_TURN:
               begin
                  smiCnt_r <= smiCnt_r + 5'h01;
                  if (smiCnt_r == 5'h00)
                  begin
                     mdioOe <= smiRead_r & smiMine_r;
                     mdioOut <= 1'b0;
                  end
                  else
                  begin
                     smiState_r <= SMI_DATA;
                     smiCnt_r <= 5'h00;
                     if (smiRead_r)
                     begin
                        mdioOut <= smiShift_r[15];
                        smiShift_r <= {smiShift_r[14:0], 1'b0};
                     end
                  end
               end
               SMI_DATA:
               begin
                  smiCnt_r <= smiCnt_r + 5'h01;
                  smiShift_r <= {smiShift_r[14:0], smiBit};
                  mdioOut <= smiShift_r[15];
                  if (smiCnt_r == 5'd15)
                  begin
                     smiState_r <= SMI_IDLE;
                     smiHist_r <= 2'b00;
                     mdioOe <= 1'b0;
                     mdioOut <= 1'b0;
                     smiWr_r <= ~smiRead_r & smiMine_r;
                     smiWrData_r <= {smiShift_r[14:0], smiBit};
                  end
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Registers and strap
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         strapDone_r <= 1'b0;
         strapVal_r <= 1'b0;
         ctrl_r <= `RMI_CTRL_RESET;
         delay_r <= `RMI_DELAY_RESET;
         extAddr_r <= 16'h0000;
      end
      else if (!strapDone_r)
      begin
         strapDone_r <= 1'b1;
         strapVal_r <= strapS2_r;
         ctrl_r[`RMI_CTRL_RGMII_EN] <= ~strapS2_r;
      end
      else if (smiWr_r)
      begin
         if (smiAddr_r == `RMI_SMI_EXTADDR)
            extAddr_r <= smiWrData_r;
         else if (smiAddr_r == `RMI_SMI_EXTDATA)
         begin
            if (extAddr_r == `RMI_REG_CTRL)
               ctrl_r <= smiWrData_r;
            else if (extAddr_r == `RMI_REG_DELAY)
               delay_r <= smiWrData_r;
         end
      end
   end

   // Delay lines are analog; the codes below pick one of 16 taps
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rgmiiMode <= 1'b0;
         txSkewSel <= 4'h0;
         rxSkewSel <= 4'h0;
      end
      else
      begin
         rgmiiMode <= ctrl_r[`RMI_CTRL_RGMII_EN];
         txSkewSel <= ctrl_r[`RMI_CTRL_TX_SHIFT] ? delay_r[7:4] : 4'h0;
         rxSkewSel <= ctrl_r[`RMI_CTRL_RX_SHIFT] ? delay_r[3:0] : 4'h0;
      end
   end

   // ------------------------------------------------------------
   // Receive clock
   // ------------------------------------------------------------
   // A new rate only takes effect on a whole phase, so a phase is
   // stretched or shortened but never cut into a glitch.
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         speed_r <= RMI_SPD_10;
         halfCnt_r <= 8'h00;
         rxClkPin <= 1'b0;
      end
      else if (halfCnt_r == 8'h00)
      begin
         rxClkPin <= ~rxClkPin;
         if (rxClkPin && !cur_r.valid && !txBusy_r && linkSpeed != speed_r)
         begin
            speed_r <= linkSpeed;
            halfCnt_r <= halfCount(linkSpeed);
         end
         else
            halfCnt_r <= halfCount(speed_r);
      end
      else
         halfCnt_r <= halfCnt_r - 8'h01;
   end

   wire riseNow = halfCnt_r == 8'h00 && !rxClkPin;
   wire fallNow = halfCnt_r == 8'h00 && rxClkPin;

   // ------------------------------------------------------------
   // Receive path
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rxdPin <= 8'h00;
         rxCtlPin <= 1'b0;
         rxErPin <= 1'b0;
         rxTake <= 1'b0;
         cur_r <= '0;
         nibHi_r <= 1'b0;
      end
      else
      begin
         rxTake <= 1'b0;
         if (riseNow && nibbleMode && nibHi_r)
         begin
            nibHi_r <= 1'b0;
            rxdPin <= {4'h0, cur_r.data[7:4]};
            rxCtlPin <= cur_r.valid;
            rxErPin <= gmii & cur_r.error;
         end
         else if (riseNow)
         begin
            cur_r <= rxBeat;
            rxTake <= 1'b1;
            nibHi_r <= nibbleMode;
            rxdPin <= (gmii && !nibbleMode) ? rxBeat.data
                      : {4'h0, rxBeat.data[3:0]};
            rxCtlPin <= rxBeat.valid;
            rxErPin <= gmii & rxBeat.error;
         end
         else if (fallNow && !gmii)
         begin
            rxCtlPin <= cur_r.valid ^ cur_r.error;
            if (!nibbleMode)
               rxdPin <= {4'h0, cur_r.data[7:4]};
            // At 10/100 the nibble simply stays for the falling edge
         end
      end
   end

   // ------------------------------------------------------------
   // Transmit path
   // ------------------------------------------------------------
   // Oversampling at twice a 125 MHz clock is too coarse; the
   // sampled path suits the 10/100 rates and slow bench clocks. A stopped
   // transmit clock simply yields no events.
   wire txRise = txS2_r[10] & ~txS3_r[10];
   wire txFall = ~txS2_r[10] & txS3_r[10];
   wire txEv = gmii ? txRise : txFall;
   wire evEn = gmii ? txS3_r[9] : riseCtl_r;
   wire evErr = gmii ? txS3_r[8] : riseCtl_r ^ txS3_r[9];
   wire [3:0] evNib = gmii ? txS3_r[3:0] : riseD_r;
   wire [7:0] evByte = gmii ? txS3_r[7:0] : {txS3_r[3:0], riseD_r};

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         riseCtl_r <= 1'b0;
         riseD_r <= 4'h0;
      end
      else if (txRise)
      begin
         riseCtl_r <= txS3_r[9];
         riseD_r <= txS3_r[3:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         txBeat <= '0;
         txStrobe <= 1'b0;
         txNib_r <= 1'b0;
         txLow_r <= 4'h0;
         txErrLow_r <= 1'b0;
         txBusy_r <= 1'b0;
      end
      else
      begin
         txStrobe <= 1'b0;
         if (txEv && !nibbleMode)
         begin
            txBeat <= {evEn, evErr, evByte};
            txStrobe <= 1'b1;
            txBusy_r <= evEn;
         end
         else if (txEv && evEn && txNib_r)
         begin
            txBeat <= {1'b1, evErr | txErrLow_r, evNib, txLow_r};
            txStrobe <= 1'b1;
            txNib_r <= 1'b0;
         end
         else if (txEv && evEn)
         begin
            txLow_r <= evNib;
            txErrLow_r <= evErr;
            txNib_r <= 1'b1;
            txBusy_r <= 1'b1;
         end
         else if (txEv)
         begin
            txNib_r <= 1'b0;
            txBusy_r <= 1'b0;
         end
      end
   end
endmodule

// file: test/rmi_mac_side_interface_chk.sv
// Port checker for the MAC-side interface
`timescale 1ns/100ps
module rmi_mac_side_interface_chk
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Observed ports
   input wire logic interfaceSelectStrapPin,
   input wire rmi_pkg::rmi_beat_type rxBeat,
   input wire logic rxTake,
   input wire rmi_pkg::rmi_beat_type txBeat,
   input wire logic txStrobe,
   input wire logic rxClkPin,
   input wire logic [7:0] rxdPin,
   input wire logic rxCtlPin,
   input wire logic rxErPin,
   input wire logic mdcPin,
   input wire logic mdioOut,
   input wire logic mdioOe,
   input wire logic rgmiiMode,
   input wire logic [3:0] txSkewSel,
   input wire logic [3:0] rxSkewSel
);
   import rmi_pkg::*;
   // ---
   // Half-period counter; first phase after reset is not judged
   // ---
   logic clkQ;
   logic armed;
   int halfCnt;
   always_ff @(posedge mclk)
   begin
      clkQ <= rxClkPin;
   end
   always_ff @(posedge mclk)
   begin
      if (srst || rxClkPin != clkQ)
         halfCnt <= 0;
      else
         halfCnt <= halfCnt + 1;
   end
   always_ff @(posedge mclk)
   begin
      if (srst)
         armed <= 1'b0;
      else if (rxClkPin != clkQ)
         armed <= 1'b1;
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   sequence s_take_fall;
      rxTake && rgmiiMode && $stable(rgmiiMode) ##1 !rxClkPin;
   endsequence
   property p_take_rise;
      rxTake |-> rxClkPin && !$past(rxClkPin);
   endproperty
   a_take_rise: assert property (p_take_rise)
      else $error("take without clock rise");
   property p_rise_ctl;
      rxTake |-> rxCtlPin == $past(rxBeat.valid);
   endproperty
   a_rise_ctl: assert property (p_rise_ctl)
      else $error("control wrong at rise");
   property p_low_nib;
      rxTake && rgmiiMode && $stable(rgmiiMode)
         |-> rxdPin == {4'h0, $past(rxBeat.data[3:0])};
   endproperty
   a_low_nib: assert property (p_low_nib)
      else $error("low nibble wrong");
   property p_fall;
      s_take_fall |-> rxdPin == {4'h0, $past(rxBeat.data[7:4], 2)}
         && rxCtlPin == ($past(rxBeat.valid, 2) ^ $past(rxBeat.error, 2));
   endproperty
   a_fall: assert property (p_fall)
      else $error("falling edge values wrong");
   property p_err_pin;
      rxTake && $stable(rgmiiMode)
         |-> rxErPin == (!rgmiiMode && $past(rxBeat.error));
   endproperty
   a_err_pin: assert property (p_err_pin)
      else $error("error pin wrong");
   property p_strap;
      $fell(srst) |-> ##[1:3] rgmiiMode == !interfaceSelectStrapPin;
   endproperty
   a_strap: assert property (p_strap)
      else $error("mode not from strap");
   property p_skew_mgmt;
      !$stable({txSkewSel, rxSkewSel}) |-> $past(mdcPin, 3);
   endproperty
   a_skew_mgmt: assert property (p_skew_mgmt)
      else $error("skew changed outside management");
   property p_mdio_ta;
      $rose(mdioOe) |-> !mdioOut && $past(mdcPin);
   endproperty
   a_mdio_ta: assert property (p_mdio_ta)
      else $error("turnaround not driven low");
   property p_half;
      armed && rxClkPin != clkQ |-> halfCnt inside {0, 4, 49};
   endproperty
   a_half: assert property (p_half)
      else $error("receive clock phase length wrong");
   property p_tx_valid;
      txStrobe |-> txBeat.valid;
   endproperty
   a_tx_valid: assert property (p_tx_valid)
      else $error("strobe without enable");
endmodule
bind rmi_mac_side_interface rmi_mac_side_interface_chk u_chk (.*);

// file: test/rmi_mac_model.sv
// Behavioural MAC transmitter on the transmit pins
`timescale 1ns/100ps
module rmi_mac_model
(
   // Transmit pins
   output logic txClk,
   output logic [7:0] txd,
   output logic txCtl,
   output logic txEr
);
   logic [3:0] nib;
   initial
   begin
      txClk = 1'b0;
      txd = 8'h00;
      txCtl = 1'b0;
      txEr = 1'b0;
   end
   // One nibble per 80 ns cycle, low nibble first; clock stands low
   // between frames, so the device never sees idle nibbles
   task frame(input logic [7:0] q[$], input logic err);
      int i;
      int h;
      for (i = 0; i < q.size(); i++)
         for (h = 0; h < 2; h++)
         begin
            nib = h ? q[i][7:4] : q[i][3:0];
            txd <= {~nib, nib};
            txCtl <= 1'b1;
            txEr <= err;
            #20 txClk <= 1'b1;
            #20 txCtl <= !err;
            #20 txClk <= 1'b0;
            #20;
         end
      txCtl <= 1'b0;
      txEr <= 1'b0;
      txd <= ~txd;
   endtask
endmodule

// file: test/test_rmi_mac_side_interface.sv
// Self-checking bench for the MAC-side interface
`timescale 1ns/100ps
`include "rmi_defs.svh"
module test_rmi_mac_side_interface;
   import rmi_pkg::*;
   logic mclk = 1'b0, srst = 1'b1, strap = 1'b1, mdc = 1'b0;
   logic stnOe = 1'b0, stnBit = 1'b1, txErrExp = 1'b0;
   rmi_speed_type speed = RMI_SPD_10;
   rmi_beat_type rxBeat = '0, txBeat;
   logic rxTake, txStrobe, rxClkPin, rxCtlPin, rxErPin, mdioOut, mdioOe;
   logic rgmiiMode, txClk, txCtl, txEr;
   logic [7:0] rxdPin, txd;
   logic [3:0] txSkewSel, rxSkewSel;
   logic [7:0] txQ[$];
   rmi_beat_type rxQ[$];
   int errorCnt = 0, numChecks = 0, cyc = 0;
   // Pull-up holds the line high when nobody drives
   wire mdioW = mdioOe ? mdioOut : (stnOe ? stnBit : 1'b1);
   always #2 mclk = ~mclk;
   rmi_mac_side_interface DUT
   (
      .mclk(mclk), .srst(srst), .interfaceSelectStrapPin(strap),
      .linkSpeed(speed), .rxBeat(rxBeat), .rxTake(rxTake),
      .txBeat(txBeat), .txStrobe(txStrobe), .rxClkPin(rxClkPin),
      .rxdPin(rxdPin), .rxCtlPin(rxCtlPin), .rxErPin(rxErPin),
      .txClkPin(txClk), .txdPin(txd), .txCtlPin(txCtl), .txErPin(txEr),
      .mdcPin(mdc), .mdioIn(mdioW), .mdioOut(mdioOut), .mdioOe(mdioOe),
      .rgmiiMode(rgmiiMode), .txSkewSel(txSkewSel), .rxSkewSel(rxSkewSel)
   );
   rmi_mac_model mac
   (
      .txClk(txClk), .txd(txd), .txCtl(txCtl), .txEr(txEr)
   );
   task check(input string what, input logic [15:0] seen, exp);
      numChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task complete_run;
      $display("Checks %0d mismatches %0d", numChecks, errorCnt);
      if (errorCnt == 0 && numChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errorCnt++;
         complete_run();
      end
   end
   always @(posedge mclk)
      if (txStrobe === 1'b1)
      begin
         check("tx data", txBeat.data, txQ.pop_front());
         check("tx error", txBeat.error, txErrExp);
      end
   // ---
   // Management frames, MDC held 6 cycles per phase
   // ---
   task smi(input logic [1:0] op, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
      logic [39:0] f;
      int i;
      f = {8'hFF, 2'b01, op, 5'h00, ra, 2'b10, wd};
      rd = 16'h0000;
      for (i = 39; i >= 0; i--)
      begin
         stnOe <= !(op == `RMI_OP_READ && i < 18);
         stnBit <= f[i];
         repeat (6) @(posedge mclk);
         if (i < 16)
            rd = {rd[14:0], mdioW};
         mdc <= 1'b1;
         repeat (6) @(posedge mclk);
         mdc <= 1'b0;
      end
      // Release on an edge of its own, so a following frame never
      // assigns the enable twice in one time step
      @(posedge mclk);
      stnOe <= 1'b0;
      @(posedge mclk);
   endtask
   task ext(input logic [1:0] op, input logic [15:0] a, wd,
      output logic [15:0] rd);
      smi(`RMI_OP_WRITE, `RMI_SMI_EXTADDR, a, rd);
      smi(op, `RMI_SMI_EXTDATA, wd, rd);
   endtask
   // Beats change only at a take, so the queue front is the captured one;
   // h is the half period in clock cycles, nibble mode when above 1
   task rx_run(input logic m, input int h);
      rmi_beat_type b, nb;
      int i, c;
      logic [7:0] lo, hi;
      logic cf;
      rxQ = {rxBeat};
      for (i = 0; i < 16; i++)
      begin
         c = 0;
         do @(posedge mclk); while (rxTake !== 1'b1 && ++c < 200);
         check("rx take", rxTake, 1'b1);
         b = rxQ.pop_front();
         nb = rmi_beat_type'(10'($urandom));
         rxBeat <= nb;
         rxQ.push_back(nb);
         lo = (m || h > 1) ? {4'h0, b.data[3:0]} : b.data;
         hi = {4'h0, b.data[7:4]};
         cf = m ? b.valid ^ b.error : b.valid;
         check("rx ctl rise", rxCtlPin, b.valid);
         check("rx d rise", rxdPin, lo);
         check("rx err", rxErPin, m ? 1'b0 : b.error);
         repeat (h) @(posedge mclk);
         check("rx ctl fall", rxCtlPin, cf);
         check("rx d fall", rxdPin, (m && h == 1) ? hi : lo);
         if (h > 1)
         begin
            repeat (h) @(posedge mclk);
            check("rx ctl rise2", rxCtlPin, b.valid);
            check("rx d rise2", rxdPin, hi);
            check("rx err2", rxErPin, m ? 1'b0 : b.error);
            repeat (h) @(posedge mclk);
            check("rx ctl fall2", rxCtlPin, cf);
            check("rx d fall2", rxdPin, hi);
         end
      end
      rxBeat <= '0;
   endtask
   initial
   begin
      logic [15:0] rd, d;
      logic [7:0] q[$];
      int k;
      void'($urandom(76));
      for (k = 1; k >= 0; k--)
      begin
         strap <= k[0];
         srst <= 1'b1;
         repeat (16) @(posedge mclk);
         srst <= 1'b0;
         repeat (4) @(posedge mclk);
         check("mode", rgmiiMode, !strap);
         ext(`RMI_OP_READ, `RMI_REG_CTRL, 16'h0000, rd);
         check("ctrl reset", rd, {8'h00, !strap, 7'h00});
         ext(`RMI_OP_WRITE, `RMI_REG_STRAP, 16'hFFFF, rd);
         ext(`RMI_OP_READ, `RMI_REG_STRAP, 16'h0000, rd);
         check("strap status", rd, {15'h0000, strap});
      end
      smi(`RMI_OP_READ, 5'h03, 16'h0000, rd);
      check("unmapped", rd, 16'h0000);
      d = {8'h00, 8'($urandom)};
      ext(`RMI_OP_WRITE, `RMI_REG_DELAY, d, rd);
      ext(`RMI_OP_READ, `RMI_REG_DELAY, 16'h0000, rd);
      check("delay", rd, d);
      for (k = 0; k < 4; k++)
      begin
         ext(`RMI_OP_WRITE, `RMI_REG_CTRL, {9'h001, 5'h00, k[1:0]}, rd);
         repeat (2) @(posedge mclk);
         check("tx skew", txSkewSel, k[1] ? d[7:4] : 4'h0);
         check("rx skew", rxSkewSel, k[0] ? d[3:0] : 4'h0);
      end
      speed <= RMI_SPD_1000;
      repeat (300) @(posedge mclk);
      rx_run(1'b1, 1);
      ext(`RMI_OP_WRITE, `RMI_REG_CTRL, 16'h0000, rd);
      rx_run(1'b0, 1);
      speed <= RMI_SPD_100;
      repeat (300) @(posedge mclk);
      rx_run(1'b0, 5);
      ext(`RMI_OP_WRITE, `RMI_REG_CTRL, 16'h0080, rd);
      rx_run(1'b1, 5);
      for (k = 0; k < 4; k++)
      begin
         ext(`RMI_OP_WRITE, `RMI_REG_CTRL, {8'h00, k[1], 7'h00}, rd);
         txErrExp = k[0];
         q = {8'($urandom), 8'($urandom), 8'($urandom)};
         txQ = q;
         mac.frame(q, k[0]);
         repeat (20) @(posedge mclk);
         check("tx drained", 16'(txQ.size()), 16'h0000);
      end
      complete_run();
   end
endmodule
